//--- design/eiwc_pkg.sv
// Purpose: Shared constants for the exception, interrupt and wake controller.
// Assumes: One system clock; exception numbers index the pending and priority stores.
// Notes: Peripheral position n is exception number 16 + n.
package eiwc_pkg;
   localparam int NUM_IRQ = 55;
   localparam int EXC_W = 7;
   localparam int EXC_COUNT = 71;
   localparam int PRIO_W = 3;
   localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
   localparam logic [EXC_W-1:0] IRQ_BASE = 7'h10;
   localparam logic [EXC_W-1:0] EXC_NONE = 7'h00;
   localparam logic [EXC_W-1:0] EXC_NMI = 7'h02;
   localparam logic [EXC_W-1:0] EXC_HARD_FAULT = 7'h03;
   localparam logic [EXC_W-1:0] EXC_MEM_FAULT = 7'h04;
   localparam logic [EXC_W-1:0] EXC_BUS_FAULT = 7'h05;
   localparam logic [EXC_W-1:0] EXC_USAGE_FAULT = 7'h06;
   localparam logic [EXC_W-1:0] EXC_SUPERVISOR_CALL = 7'h0b;
   localparam logic [EXC_W-1:0] EXC_DEBUG_MON = 7'h0c;
   localparam logic [EXC_W-1:0] EXC_PENDABLE_SERVICE = 7'h0e;
   localparam logic [EXC_W-1:0] EXC_SYSTEM_TICK = 7'h0f;
   // Exception numbers whose priority software may program.
   localparam logic [EXC_COUNT-1:0] PROG_MASK = {{NUM_IRQ{1'b1}}, 16'hd870};
   // Reserved peripheral positions 4, 7, 11, 12 and 40 to 43.
   localparam logic [NUM_IRQ-1:0] RESERVED_MASK = 55'h00f0000001890;
   // Positions that may wake from the deep modes: 0 to 10 less the reserved ones.
   localparam logic [NUM_IRQ-1:0] DEEP_WAKE_MASK = 55'h000000000076f;
   localparam int IRQ_LVD0 = 13;
   localparam int IRQ_LVD1 = 49;
   localparam int IRQ_DMA_ERR = 25;
   localparam int IRQ_DMA_DONE_BASE = 26;
   localparam int DMA_CHANNELS = 14;
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_LIGHT = 2'h1;
   localparam logic [1:0] MODE_DEEP2 = 2'h2;
   localparam logic [1:0] MODE_DEEP3 = 2'h3;
   typedef enum logic [2:0] {
      EIWC_ST_ACTIVE = 3'b001,
      EIWC_ST_LIGHT = 3'b010,
      EIWC_ST_DEEP = 3'b100
   } eiwc_state_e;
endpackage

//--- design/eiwc_prio_mem.sv
// Purpose: Priority store, one three-bit level per exception number.
// Assumes: Writes to fixed-priority or reserved system numbers are dropped.
// Notes: Read data come from a register one cycle after the index.
`timescale 1ns/1ps
`default_nettype none
module eiwc_prio_mem
   import eiwc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_wr_en,
   input wire logic [EXC_W-1:0] i_wr_idx,
   input wire logic [PRIO_W-1:0] i_wr_data,
   input wire logic [EXC_W-1:0] i_rd_idx,
   output logic [PRIO_W-1:0] o_rd_data_q,
   output logic [EXC_COUNT*PRIO_W-1:0] o_all
);
   logic [PRIO_W-1:0] mem_q [EXC_COUNT];

   genvar g;
   generate
      for (g = 0; g < EXC_COUNT; g++)
      begin : g_entry
         always_ff @(posedge i_clock or posedge i_sys_rst)
         begin
            if (i_sys_rst)
            begin
               mem_q[g] <= PRIO_RESET;
            end
            else if (i_wr_en && PROG_MASK[g] && i_wr_idx == EXC_W'(g))
            begin
               mem_q[g] <= i_wr_data;
            end
         end
         assign o_all[g*PRIO_W +: PRIO_W] = mem_q[g];
      end
   endgenerate

   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_rd_data_q <= PRIO_RESET;
      end
      else if (i_rd_idx < EXC_W'(EXC_COUNT))
      begin
         o_rd_data_q <= mem_q[i_rd_idx];
      end
      else
      begin
         o_rd_data_q <= PRIO_RESET;
      end
   end
endmodule
`default_nettype wire

//--- design/eiwc_top.sv
// Purpose: Exception and peripheral interrupt controller with low-power wake logic.
// Assumes: All inputs are synchronous to i_clock; a lower level value is more urgent.
// Notes: Summary of operation follows.
`timescale 1ns/1ps
`default_nettype none
module eiwc_top
   import eiwc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [NUM_IRQ-1:0] i_periph_irq,
   input wire logic [DMA_CHANNELS-1:0] i_dma_done,
   input wire logic i_dma_err,
   input wire logic [1:0] i_lvd_irq,
   input wire logic [NUM_IRQ-1:0] i_irq_enable,
   input wire logic i_mem_fault,
   input wire logic i_bus_fault,
   input wire logic i_usage_fault,
   input wire logic [2:0] i_fault_handler_en,
   input wire logic i_svc_exec,
   input wire logic i_debug_req,
   input wire logic i_pend_service_set,
   input wire logic i_system_tick,
   input wire logic i_exc_ack,
   input wire logic [EXC_W-1:0] i_exc_ack_num,
   input wire logic i_in_handler,
   input wire logic [PRIO_W-1:0] i_active_prio,
   input wire logic i_prio_wr,
   input wire logic [EXC_W-1:0] i_prio_idx,
   input wire logic [PRIO_W-1:0] i_prio_wdata,
   input wire logic [EXC_W-1:0] i_prio_rd_idx,
   input wire logic i_sleep_req,
   input wire logic [1:0] i_sleep_mode,
   output logic o_exc_valid,
   output logic [EXC_W-1:0] o_exc_num,
   output logic [PRIO_W-1:0] o_exc_prio,
   output logic [PRIO_W-1:0] o_prio_rdata,
   output logic [1:0] o_power_mode,
   output logic o_wake
);
   logic [EXC_COUNT*PRIO_W-1:0] prio_all;
   logic [NUM_IRQ-1:0] irq_src;
   logic [EXC_COUNT-1:0] set_vec;
   logic [EXC_COUNT-1:0] elig;
   logic [EXC_COUNT-1:0] pend_q;
   logic [NUM_IRQ-1:0] wake_vec;
   logic any_fault_unhandled;
   logic best_valid;
   logic [EXC_W-1:0] best_num;
   logic [PRIO_W-1:0] best_prio;
   logic o_exc_valid_q;
   logic [EXC_W-1:0] o_exc_num_q;
   logic [PRIO_W-1:0] o_exc_prio_q;
   logic [1:0] o_power_mode_q;
   logic o_wake_q;
   eiwc_state_e state_q;
   logic limit_on_q;
   logic [PRIO_W-1:0] limit_q;

   eiwc_prio_mem u_prio_mem (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_wr_en(i_prio_wr),
      .i_wr_idx(i_prio_idx),
      .i_wr_data(i_prio_wdata),
      .i_rd_idx(i_prio_rd_idx),
      .o_rd_data_q(o_prio_rdata),
      .o_all(prio_all)
   );

   // Source map: DMA, low-voltage and general peripheral lines merged by position.
   always_comb
   begin
      irq_src = i_periph_irq;
      irq_src[IRQ_DMA_ERR] = i_periph_irq[IRQ_DMA_ERR] | i_dma_err;
      irq_src[IRQ_DMA_DONE_BASE +: DMA_CHANNELS] =
         i_periph_irq[IRQ_DMA_DONE_BASE +: DMA_CHANNELS] | i_dma_done;
      irq_src[IRQ_LVD0] = i_periph_irq[IRQ_LVD0] | i_lvd_irq[0];
      irq_src[IRQ_LVD1] = i_periph_irq[IRQ_LVD1] | i_lvd_irq[1];
      irq_src = irq_src & ~RESERVED_MASK;
   end

   assign any_fault_unhandled = (i_mem_fault && !i_fault_handler_en[0])
      || (i_bus_fault && !i_fault_handler_en[1])
      || (i_usage_fault && !i_fault_handler_en[2]);

   // Set requests per exception number; the nonmaskable slot has no source.
   always_comb
   begin
      set_vec = '0;
      set_vec[EXC_NMI] = 1'b0;
      set_vec[EXC_HARD_FAULT] = any_fault_unhandled;
      set_vec[EXC_MEM_FAULT] = i_mem_fault && i_fault_handler_en[0];
      set_vec[EXC_BUS_FAULT] = i_bus_fault && i_fault_handler_en[1];
      set_vec[EXC_USAGE_FAULT] = i_usage_fault && i_fault_handler_en[2];
      set_vec[EXC_SUPERVISOR_CALL] = i_svc_exec;
      set_vec[EXC_DEBUG_MON] = i_debug_req;
      set_vec[EXC_PENDABLE_SERVICE] = i_pend_service_set;
      set_vec[EXC_SYSTEM_TICK] = i_system_tick;
      set_vec[EXC_COUNT-1:IRQ_BASE] = irq_src;
      elig = {i_irq_enable & ~RESERVED_MASK, 16'hd878};
   end

   // Pending flags: a set in the acknowledge cycle wins over the clear.
   genvar g;
   generate
      for (g = 0; g < EXC_COUNT; g++)
      begin : g_pend
         always_ff @(posedge i_clock or posedge i_sys_rst)
         begin
            if (i_sys_rst)
            begin
               pend_q[g] <= 1'b0;
            end
            else if (set_vec[g])
            begin
               pend_q[g] <= 1'b1;
            end
            else if (i_exc_ack && i_exc_ack_num == EXC_W'(g))
            begin
               pend_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Hard fault outranks all; otherwise lowest level, ties to lowest number.
   always_comb
   begin
      best_valid = 1'b0;
      best_num = EXC_NONE;
      best_prio = PRIO_RESET;
      if (pend_q[EXC_HARD_FAULT])
      begin
         best_valid = 1'b1;
         best_num = EXC_HARD_FAULT;
      end
      else
      begin
         for (int k = 4; k < EXC_COUNT; k++)
         begin
            if (pend_q[k] && elig[k] &&
               (!best_valid || prio_all[k*PRIO_W +: PRIO_W] < best_prio))
            begin
               best_valid = 1'b1;
               best_num = EXC_W'(k);
               best_prio = prio_all[k*PRIO_W +: PRIO_W];
            end
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_exc_valid_q <= 1'b0;
         o_exc_num_q <= EXC_NONE;
         o_exc_prio_q <= PRIO_RESET;
      end
      else
      begin
         o_exc_valid_q <= best_valid;
         o_exc_num_q <= best_num;
         o_exc_prio_q <= best_prio;
      end
   end

   // Wake candidates per position, gated by mode and by the handler limit.
   generate
      for (g = 0; g < NUM_IRQ; g++)
      begin : g_wake
         assign wake_vec[g] = pend_q[g+16] && i_irq_enable[g] && !RESERVED_MASK[g]
            && (state_q != EIWC_ST_DEEP || DEEP_WAKE_MASK[g])
            && (!limit_on_q || prio_all[(g+16)*PRIO_W +: PRIO_W] < limit_q);
      end
   endgenerate

   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state_q <= EIWC_ST_ACTIVE;
         o_power_mode_q <= MODE_ACTIVE;
         o_wake_q <= 1'b0;
         limit_on_q <= 1'b0;
         limit_q <= PRIO_RESET;
      end
      else
      begin
         o_wake_q <= 1'b0;
         case (state_q)
            EIWC_ST_ACTIVE:
            begin
               if (i_sleep_req && i_sleep_mode != MODE_ACTIVE)
               begin
                  state_q <= (i_sleep_mode == MODE_LIGHT) ? EIWC_ST_LIGHT : EIWC_ST_DEEP;
                  o_power_mode_q <= i_sleep_mode;
                  limit_on_q <= i_in_handler;
                  limit_q <= i_active_prio;
               end
            end
            EIWC_ST_LIGHT, EIWC_ST_DEEP:
            begin
               if (|wake_vec)
               begin
                  state_q <= EIWC_ST_ACTIVE;
                  o_power_mode_q <= MODE_ACTIVE;
                  o_wake_q <= 1'b1;
                  limit_on_q <= 1'b0;
               end
            end
            default:
            begin
               state_q <= EIWC_ST_ACTIVE;
               o_power_mode_q <= MODE_ACTIVE;
            end
         endcase
      end
   end

   assign o_exc_valid = o_exc_valid_q;
   assign o_exc_num = o_exc_num_q;
   assign o_exc_prio = o_exc_prio_q;
   assign o_power_mode = o_power_mode_q;
   assign o_wake = o_wake_q;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);

   a_nmi_never: assert property (o_exc_num != EXC_NMI)
      else $error("Nonmaskable exception was presented.");
   a_fault_escalate: assert property (i_bus_fault && !i_fault_handler_en[1]
      |=> ##1 o_exc_valid && o_exc_num == EXC_HARD_FAULT)
      else $error("Unhandled fault did not escalate to hard fault.");
   a_bus_pend: assert property (i_bus_fault && i_fault_handler_en[1] |=> pend_q[EXC_BUS_FAULT])
      else $error("Bus fault did not pend.");
   a_usage_pend: assert property (i_usage_fault && i_fault_handler_en[2]
      |=> pend_q[EXC_USAGE_FAULT])
      else $error("Usage fault did not pend.");
   a_svc_pend: assert property (i_svc_exec |=> pend_q[EXC_SUPERVISOR_CALL])
      else $error("Supervisor call did not pend.");
   a_debug_pend: assert property (i_debug_req |=> pend_q[EXC_DEBUG_MON])
      else $error("Debug request did not pend.");
   a_service_hold: assert property (pend_q[EXC_PENDABLE_SERVICE] && !(i_exc_ack
      && i_exc_ack_num == EXC_PENDABLE_SERVICE) |=> pend_q[EXC_PENDABLE_SERVICE])
      else $error("Pendable service request was lost.");
   a_deep_wake_src: assert property (state_q == EIWC_ST_DEEP && o_power_mode_q != MODE_ACTIVE
      ##1 state_q == EIWC_ST_ACTIVE |-> $past(|(pend_q[70:16] & DEEP_WAKE_MASK)))
      else $error("Deep mode woke from a source outside the deep set.");
   a_wake_mode0: assert property (o_wake |-> o_power_mode == MODE_ACTIVE
      && $past(o_power_mode) != MODE_ACTIVE)
      else $error("Wake did not return to active mode.");
   a_light_wake: assert property (state_q == EIWC_ST_LIGHT && !limit_on_q
      && |(pend_q[70:16] & i_irq_enable & ~RESERVED_MASK) |=> o_wake)
      else $error("Light sleep failed to wake on an enabled source.");
   a_reserved_idle: assert property ((pend_q[70:16] & RESERVED_MASK) == '0)
      else $error("Reserved position became pending.");
   a_dma_map: assert property (i_dma_done[0] |=> pend_q[IRQ_DMA_DONE_BASE+16])
      else $error("DMA channel 0 done did not pend at its position.");
   a_prio_reset: assert property ($fell(i_sys_rst) |-> prio_all == '0)
      else $error("Priorities not at level zero after reset.");

   c_deep_wake: cover property (state_q == EIWC_ST_DEEP ##1 o_wake);
   c_light_wake: cover property (state_q == EIWC_ST_LIGHT ##1 o_wake);
   c_hard_fault: cover property (o_exc_num == EXC_HARD_FAULT);
   c_limited_sleep: cover property (limit_on_q && state_q == EIWC_ST_LIGHT);
endmodule
`default_nettype wire

//--- sim/eiwc_core_model.sv
// Purpose: Core model that takes and acknowledges selected exceptions.
// Assumes: It acknowledges only in active mode and pauses between takes.
// Notes: The ack number keeps changing while no ack is given.
`timescale 1ns/1ps
`default_nettype none
module eiwc_core_model
   import eiwc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_exc_valid,
   input wire logic [EXC_W-1:0] i_exc_num,
   input wire logic [1:0] i_power_mode,
   input wire logic [3:0] i_delay,
   output logic o_ack,
   output logic [EXC_W-1:0] o_ack_num,
   output logic [EXC_W-1:0] o_taken_num,
   output logic [7:0] o_taken_cnt
);
   logic [3:0] wait_q;
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_ack <= 1'b0;
         o_ack_num <= 7'h00;
         o_taken_num <= 7'h00;
         o_taken_cnt <= 8'h00;
         wait_q <= 4'h0;
      end
      else
      begin
         o_ack <= 1'b0;
         o_ack_num <= ~o_ack_num;
         if (wait_q != 4'h0)
            wait_q <= wait_q - 4'h1;
         else if (i_exc_valid && i_power_mode == MODE_ACTIVE)
         begin
            o_ack <= 1'b1;
            o_ack_num <= i_exc_num;
            o_taken_num <= i_exc_num;
            o_taken_cnt <= o_taken_cnt + 8'h01;
            wait_q <= 4'h3 + i_delay;
         end
      end
   end
endmodule
`default_nettype wire

//--- sim/tb.sv
// Purpose: Self-checking bench for the exception and wake controller.
// Assumes: A core model acknowledges what the controller selects.
// Notes: Single sources run from a table; the rest are hand-written.
`timescale 1ns/1ps
`default_nettype none
module tb
   import eiwc_pkg::*;
   ;
   typedef struct {int s; int x; logic [2:0] h; logic [EXC_W-1:0] e;} eiwc_row_s;
   logic i_clock = 1'b0, i_sys_rst = 1'b1, i_dma_err = 1'b0, i_mem_fault = 1'b0;
   logic [NUM_IRQ-1:0] i_periph_irq = '0, i_irq_enable = '1;
   logic [DMA_CHANNELS-1:0] i_dma_done = '0;
   logic [1:0] i_lvd_irq = '0, i_sleep_mode = 2'h0, o_power_mode;
   logic i_bus_fault = 1'b0, i_usage_fault = 1'b0, i_svc_exec = 1'b0, i_debug_req = 1'b0;
   logic i_pend_service_set = 1'b0, i_system_tick = 1'b0, i_in_handler = 1'b0;
   logic i_prio_wr = 1'b0, i_sleep_req = 1'b0, i_exc_ack, o_exc_valid, o_wake;
   logic [2:0] i_fault_handler_en = 3'h7;
   logic [EXC_W-1:0] i_exc_ack_num, i_prio_idx = 7'h00, i_prio_rd_idx = 7'h10, o_exc_num;
   logic [EXC_W-1:0] taken_num;
   logic [PRIO_W-1:0] i_active_prio = 3'h0, i_prio_wdata = 3'h0, o_exc_prio, o_prio_rdata;
   logic [7:0] taken_cnt;
   logic [3:0] core_delay = 4'h0;
   int fail_count = 0, n_compared = 0, cyc = 0;
   eiwc_row_s rows [17] = '{
      '{0, 0, 3'h7, 7'h10}, '{0, 54, 3'h7, 7'h46}, '{1, 0, 3'h7, 7'h2a},
      '{1, 13, 3'h7, 7'h37}, '{2, 0, 3'h7, 7'h29}, '{3, 0, 3'h7, 7'h1d},
      '{3, 1, 3'h7, 7'h41}, '{4, 0, 3'h7, 7'h0b}, '{5, 0, 3'h7, 7'h0c},
      '{6, 0, 3'h7, 7'h0e}, '{7, 0, 3'h7, 7'h0f}, '{8, 0, 3'h7, 7'h04},
      '{9, 0, 3'h7, 7'h05}, '{10, 0, 3'h7, 7'h06}, '{8, 0, 3'h6, 7'h03},
      '{9, 0, 3'h5, 7'h03}, '{10, 0, 3'h3, 7'h03}};
   eiwc_top dut_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_periph_irq(i_periph_irq),
      .i_dma_done(i_dma_done), .i_dma_err(i_dma_err), .i_lvd_irq(i_lvd_irq),
      .i_irq_enable(i_irq_enable), .i_mem_fault(i_mem_fault), .i_bus_fault(i_bus_fault),
      .i_usage_fault(i_usage_fault), .i_fault_handler_en(i_fault_handler_en),
      .i_svc_exec(i_svc_exec), .i_debug_req(i_debug_req),
      .i_pend_service_set(i_pend_service_set), .i_system_tick(i_system_tick),
      .i_exc_ack(i_exc_ack), .i_exc_ack_num(i_exc_ack_num), .i_in_handler(i_in_handler),
      .i_active_prio(i_active_prio), .i_prio_wr(i_prio_wr), .i_prio_idx(i_prio_idx),
      .i_prio_wdata(i_prio_wdata), .i_prio_rd_idx(i_prio_rd_idx), .i_sleep_req(i_sleep_req),
      .i_sleep_mode(i_sleep_mode), .o_exc_valid(o_exc_valid), .o_exc_num(o_exc_num),
      .o_exc_prio(o_exc_prio), .o_prio_rdata(o_prio_rdata), .o_power_mode(o_power_mode),
      .o_wake(o_wake));
   eiwc_core_model core_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_exc_valid(o_exc_valid), .i_exc_num(o_exc_num), .i_power_mode(o_power_mode),
      .i_delay(core_delay), .o_ack(i_exc_ack), .o_ack_num(i_exc_ack_num),
      .o_taken_num(taken_num), .o_taken_cnt(taken_cnt));
   always #5 i_clock = ~i_clock;
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(logic [7:0] got, logic [7:0] exp, string m);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic fire(int s, int x, logic [2:0] h);
      @(posedge i_clock);
      i_fault_handler_en <= h;
      case (s)
         0: i_periph_irq[x] <= 1'b1;
         1: i_dma_done[x] <= 1'b1;
         2: i_dma_err <= 1'b1;
         3: i_lvd_irq[x] <= 1'b1;
         4: i_svc_exec <= 1'b1;
         5: i_debug_req <= 1'b1;
         6: i_pend_service_set <= 1'b1;
         7: i_system_tick <= 1'b1;
         8: i_mem_fault <= 1'b1;
         9: i_bus_fault <= 1'b1;
         default: i_usage_fault <= 1'b1;
      endcase
      @(posedge i_clock);
      {i_periph_irq, i_dma_done, i_lvd_irq, i_dma_err, i_svc_exec, i_debug_req,
         i_pend_service_set, i_system_tick, i_mem_fault, i_bus_fault, i_usage_fault} <= '0;
   endtask
   task automatic take(logic [EXC_W-1:0] e);
      logic [7:0] c;
      int n;
      c = taken_cnt;
      n = 0;
      while (taken_cnt === c && n < 40)
      begin
         @(posedge i_clock);
         n++;
      end
      chk(taken_cnt - c, 8'h01, "take count");
      chk({1'b0, taken_num}, {1'b0, e}, "taken exception");
   endtask
   task automatic prio(logic [EXC_W-1:0] x, logic [2:0] d);
      @(posedge i_clock);
      i_prio_wr <= 1'b1;
      i_prio_idx <= x;
      i_prio_wdata <= d;
      @(posedge i_clock);
      i_prio_wr <= 1'b0;
   endtask
   task automatic rd(logic [EXC_W-1:0] x, logic [2:0] e);
      @(posedge i_clock);
      i_prio_rd_idx <= x;
      repeat (2) @(posedge i_clock);
      #1;
      chk({5'h0, o_prio_rdata}, {5'h0, e}, "priority read");
   endtask
   task automatic sleep(logic [1:0] m);
      repeat (20) @(posedge i_clock);
      i_sleep_req <= 1'b1;
      i_sleep_mode <= m;
      @(posedge i_clock);
      i_sleep_req <= 1'b0;
      @(posedge i_clock);
      #1;
      chk({6'h0, o_power_mode}, {6'h0, m}, "sleep mode");
   endtask
   task automatic wk(int s, int x, logic ew, logic [1:0] em);
      logic w;
      fire(s, x, 3'h7);
      w = 1'b0;
      repeat (8)
      begin
         @(posedge i_clock);
         #1;
         if (o_wake === 1'b1)
            w = 1'b1;
      end
      chk({7'h0, w}, {7'h0, ew}, "wake");
      chk({6'h0, o_power_mode}, {6'h0, em}, "mode after wake");
   endtask
   always @(posedge i_clock)
   begin
      cyc++;
      if (o_exc_valid === 1'b1 && o_exc_num === EXC_NMI)
         chk({1'b0, o_exc_num}, 8'hff, "nonmaskable raised");
      if (cyc == 6000)
      begin
         fail_count++;
         $display("FAIL t=%0t timeout", $time);
         end_of_test();
      end
   end
   initial
   begin
      repeat (4) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      @(posedge i_clock);
      #1;
      chk({o_exc_valid, o_exc_num}, 8'h00, "reset exception");
      chk({o_exc_prio, o_prio_rdata, o_power_mode}, 8'h00, "reset outputs");
      chk({7'h0, o_wake}, 8'h00, "reset wake");
      $display("test reset done");
      foreach (rows[i])
      begin
         fire(rows[i].s, rows[i].x, rows[i].h);
         take(rows[i].e);
      end
      $display("test sources done");
      core_delay <= 4'h5;
      prio(7'h23, 3'h1);
      prio(7'h24, 3'h1);
      prio(7'h13, 3'h2);
      prio(7'h07, 3'h5);
      rd(7'h23, 3'h1);
      rd(7'h07, 3'h0);
      @(posedge i_clock);
      i_periph_irq <= 55'h180008;
      @(posedge i_clock);
      i_periph_irq <= '0;
      @(posedge i_clock);
      #1;
      chk({1'b0, o_exc_num}, 8'h23, "first of equal levels");
      chk({5'h0, o_exc_prio}, 8'h01, "selected level");
      take(7'h23);
      take(7'h24);
      take(7'h13);
      core_delay <= 4'h0;
      $display("test priority done");
      i_irq_enable[18] <= 1'b0;
      fire(0, 18, 3'h7);
      repeat (6) @(posedge i_clock);
      #1;
      chk({7'h0, o_exc_valid}, 8'h00, "disabled selected");
      i_irq_enable[18] <= 1'b1;
      take(7'h22);
      for (int i = 0; i < NUM_IRQ; i++)
      begin
         if (RESERVED_MASK[i])
         begin
            fire(0, i, 3'h7);
         end
      end
      repeat (4) @(posedge i_clock);
      #1;
      chk({7'h0, o_exc_valid}, 8'h00, "reserved selected");
      $display("test enable and reserved done");
      sleep(MODE_DEEP2);
      wk(0, 4, 1'b0, MODE_DEEP2);
      wk(0, 15, 1'b0, MODE_DEEP2);
      wk(0, 0, 1'b1, MODE_ACTIVE);
      sleep(MODE_DEEP3);
      wk(3, 0, 1'b0, MODE_DEEP3);
      wk(0, 10, 1'b1, MODE_ACTIVE);
      sleep(MODE_LIGHT);
      wk(3, 1, 1'b1, MODE_ACTIVE);
      $display("test wake done");
      i_in_handler <= 1'b1;
      i_active_prio <= 3'h2;
      sleep(MODE_LIGHT);
      wk(0, 3, 1'b0, MODE_LIGHT);
      wk(0, 19, 1'b1, MODE_ACTIVE);
      i_in_handler <= 1'b0;
      $display("test handler wake done");
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      rd(7'h23, 3'h0);
      chk({o_exc_valid, o_exc_num}, 8'h00, "second reset exception");
      $display("test second reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
